/* File: rtl/pidc_top.sv */
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps
module pidc_top #(
   parameter int TICK_CYCLES = pidc_pkg::TICK_CYC
) (
   input  wire  logic                              pclk,
   input  wire  logic                              presetn,
   input  wire  logic                              psel,
   input  wire  logic                              penable,
   input  wire  logic                              pwrite,
   input  wire  logic [11:0]                       paddr,
   input  wire  logic [31:0]                       pwdata,
   output logic [31:0]                             prdata,
   output logic                                    pready,
   output logic                                    pslverr,
   input  wire  logic signed [pidc_pkg::DW-1:0]    target,
   input  wire  logic signed [pidc_pkg::DW-1:0]    freq_ref,
   input  wire  logic signed [pidc_pkg::DW-1:0]    feedback_in,
   input  wire  logic signed [pidc_pkg::DW-1:0]    mon_current,
   input  wire  logic signed [pidc_pkg::DW-1:0]    mon_speed,
   input  wire  logic signed [pidc_pkg::DW-1:0]    mon_voltage,
   input  wire  logic signed [pidc_pkg::DW-1:0]    mon_bus,
   input  wire  logic signed [pidc_pkg::DW-1:0]    mon_power,
   input  wire  logic signed [pidc_pkg::DW-1:0]    mon_torque,
   input  wire  logic signed [pidc_pkg::DW-1:0]    mon_a1,
   input  wire  logic signed [pidc_pkg::DW-1:0]    mon_a2,
   input  wire  logic signed [pidc_pkg::DW-1:0]    mon_secondary,
   input  wire  logic [pidc_pkg::NDIN-1:0]         din,
   output logic signed [pidc_pkg::DW-1:0]          freq_out,
   output logic                                    run_enable,
   output logic                                    feedback_loss_event,
   output logic                                    fault_out
);
   import pidc_pkg::*;

   typedef struct packed {
      logic [NCFG-1:0][31:0] cfg;
      logic [31:0]           rdata;
      logic                  ready;
      logic                  err;
      logic [NDIN-1:0]       din_m;
      logic [NDIN-1:0]       din_s;
      logic                  ireset_p;
      logic [31:0]           tick_cnt;
      logic signed [15:0]    ramp;
      logic signed [31:0]    integ;
      logic signed [31:0]    filt;
      logic signed [15:0]    fout;
      logic [31:0]           loss_cnt;
      logic                  alarm;
      logic                  fault;
      logic [31:0]           sleep_cnt;
      logic                  sleeping;
      logic                  run;
      logic                  evt;
   } pidc_state_t;

   pidc_state_t s_q;
   pidc_state_t s_d;

   function automatic logic [9:0] pidc_isqrt(input logic [19:0] v);
      logic [9:0]  q;
      logic [9:0]  t;
      logic [19:0] sq;
      q = '0;
      for (int b = 9; b >= 0; b--) begin
         t  = q | (10'h001 << b);
         sq = {10'h000, t} * {10'h000, t};
         if (sq <= v) begin
            q = t;
         end
      end
      return q;
   endfunction : pidc_isqrt

   function automatic logic signed [31:0] pidc_sat(input logic signed [31:0] x,
                                                   input logic [15:0]        lim);
      logic signed [31:0] l;
      l = $signed({16'h0000, lim});
      if (x > l) begin
         return l;
      end else if (x < -l) begin
         return -l;
      end
      return x;
   endfunction : pidc_sat

   logic [4:0]         idx;
   logic               setup;
   logic               access;
   logic               tick;
   logic [NDIN-1:0]    fn_dis;
   logic [NDIN-1:0]    fn_irs;
   logic [NDIN-1:0]    fn_ihd;
   logic [NDIN-1:0]    fn_byp;
   logic [NDIN-1:0]    fn_inv;
   logic               dis;
   logic               irs;
   logic               ihd;
   logic               byp;
   logic               inv;
   logic               ctl_on;
   logic [15:0]        ctrl;
   logic signed [15:0] fb_sel;
   logic signed [31:0] fb;
   logic [19:0]        fb_sh;
   logic signed [31:0] dev;
   logic signed [31:0] pterm;
   logic signed [31:0] inew;
   logic signed [31:0] res;
   logic               fset;
   logic signed [31:0] step;
   logic signed [31:0] rdiff;
   logic signed [31:0] outv;
   logic signed [31:0] cmpv;
   logic               low;
   logic               high;
   logic               loss_cond;
   logic [2:0]         lmode;

   assign idx    = paddr[6:2];
   assign setup  = psel && !penable;
   assign access = psel && penable && s_q.ready;
   assign tick   = (s_q.tick_cnt == 32'(TICK_CYCLES - 1));

   always_comb begin
      s_d     = s_q;
      fset    = 1'b0;
      ctrl    = s_q.cfg[R_CTRL][15:0];
      lmode   = ctrl[C_LMODE +: 3];
      fn_dis  = '0;
      fn_irs  = '0;
      fn_ihd  = '0;
      fn_byp  = '0;
      fn_inv  = '0;
      for (int i = 0; i < NDIN; i++) begin
         fn_dis[i] = s_q.din_s[i] && (s_q.cfg[R_DIN][i*FW +: FW] == F_DISABLE);
         fn_irs[i] = s_q.din_s[i] && (s_q.cfg[R_DIN][i*FW +: FW] == F_IRESET);
         fn_ihd[i] = s_q.din_s[i] && (s_q.cfg[R_DIN][i*FW +: FW] == F_IHOLD);
         fn_byp[i] = s_q.din_s[i] && (s_q.cfg[R_DIN][i*FW +: FW] == F_SOFTBYP);
         fn_inv[i] = s_q.din_s[i] && (s_q.cfg[R_DIN][i*FW +: FW] == F_INVERT);
      end
      dis    = |fn_dis;
      irs    = |fn_irs;
      ihd    = |fn_ihd;
      byp    = |fn_byp;
      inv    = |fn_inv;
      ctl_on = ctrl[C_EN] && !dis;

      // Pin synchroniser, second stage only is read
      s_d.din_m = din;
      s_d.din_s = s_q.din_m;
      s_d.tick_cnt = tick ? 32'h0000_0000 : s_q.tick_cnt + 32'h0000_0001;

      // APB slave: ready one cycle into access phase
      s_d.ready = psel && penable && !s_q.ready;
      if (psel && penable && !s_q.ready) begin
         s_d.err   = (idx > R_OUT) || (paddr[11:7] != 5'h00);
         s_d.rdata = 32'h0000_0000;
         // Unmapped access reads as zero
         if (s_d.err) begin
            s_d.rdata = 32'h0000_0000;
         end else if (idx < R_STAT) begin
            s_d.rdata = s_q.cfg[idx];
         end else if (idx == R_STAT) begin
            s_d.rdata = {28'h000_0000, s_q.sleeping, ctl_on, s_q.fault, s_q.alarm};
         end else if (idx == R_OUT) begin
            s_d.rdata = {{16{s_q.fout[15]}}, s_q.fout};
         end
      end else if (!setup) begin
         s_d.err = 1'b0;
      end

      case (ctrl[C_MSEL +: 5])
         M_CURR:  fb_sel = mon_current;
         M_SPEED: fb_sel = mon_speed;
         M_VOLT:  fb_sel = mon_voltage;
         M_BUS:   fb_sel = mon_bus;
         M_POWER: fb_sel = mon_power;
         M_TORQ:  fb_sel = mon_torque;
         M_A1:    fb_sel = mon_a1;
         M_A2:    fb_sel = mon_a2;
         M_SEC:   fb_sel = mon_secondary;
         default: fb_sel = feedback_in;
      endcase
      // With C_SQRT set, negative feedback reads as zero; beyond the root range it saturates
      if (fb_sel[15]) begin
         fb_sh = 20'h0_0000;
      end else if (|fb_sel[14:10]) begin
         fb_sh = 20'hf_ffff;
      end else begin
         fb_sh = {fb_sel[9:0], 10'h000};
      end
      if (ctrl[C_SQRT]) begin
         fb = ($signed({22'h00_0000, pidc_isqrt(fb_sh)})
               * $signed({16'h0000, s_q.cfg[R_SQG][15:0]})) >>> GAIN_SHIFT;
      end else begin
         fb = 32'(fb_sel);
      end

      dev = 32'(s_q.ramp) - fb;
      if (inv) begin
         dev = -dev;
      end
      pterm = (dev * $signed({16'h0000, s_q.cfg[R_KP][15:0]})) >>> GAIN_SHIFT;
      inew  = pidc_sat(s_q.integ
                       + ((dev * $signed({16'h0000, s_q.cfg[R_KI][15:0]})) >>> GAIN_SHIFT),
                       s_q.cfg[R_ILIM][15:0]);
      res = pterm + s_q.integ + 32'($signed(s_q.cfg[R_OFS][15:0]));
      if (ctrl[C_POL]) begin
         res = -res;
      end
      res = (res * $signed({16'h0000, s_q.cfg[R_GAIN][15:0]})) >>> GAIN_SHIFT;
      res = pidc_sat(res, s_q.cfg[R_OLIM][15:0]);
      if (res < 0 && (!ctrl[C_NEG] || ctrl[C_REVP])) begin
         res = 32'sh0000_0000;
      end

      step  = $signed({16'h0000, s_q.cfg[R_RAMP][15:0]});
      rdiff = 32'(target) - 32'(s_q.ramp);
      if (ctrl[C_METH +: 3] == METH_ADD3 || ctrl[C_METH +: 3] == METH_ADD4) begin
         outv = 32'(freq_ref) + s_q.filt;
      end else begin
         outv = s_q.filt;
      end
      if (!ctl_on) begin
         outv = 32'(target);
      end
      cmpv = ctl_on ? s_q.filt : 32'(freq_ref);
      low  = fb < $signed({16'h0000, s_q.cfg[R_LLVL][15:0]});
      high = fb > $signed({16'h0000, s_q.cfg[R_LLVL][15:0]});
      loss_cond = ((lmode == LM_LOW_AL || lmode == LM_LOW_FT) && low)
                  || ((lmode == LM_HIGH_AL || lmode == LM_HIGH_FT) && high);

      if (tick) begin
         s_d.ireset_p = irs;
         if (byp) begin
            s_d.ramp = target;
         end else if (rdiff > step) begin
            s_d.ramp = 16'(32'(s_q.ramp) + step);
         end else if (rdiff < -step) begin
            s_d.ramp = 16'(32'(s_q.ramp) - step);
         end else begin
            s_d.ramp = target;
         end
         if (irs && !s_q.ireset_p) begin
            s_d.integ = 32'sh0000_0000;
         end else if (!ihd && ctl_on) begin
            s_d.integ = inew;
         end
         s_d.filt = s_q.filt + ((res - s_q.filt) >>> s_q.cfg[R_FILT][3:0]);
         s_d.fout = 16'(outv);

         if (!loss_cond) begin
            s_d.loss_cnt = 32'h0000_0000;
            s_d.alarm    = 1'b0;
         end else if (s_q.loss_cnt >= s_q.cfg[R_LTIM]) begin
            s_d.alarm = (lmode == LM_LOW_AL) || (lmode == LM_HIGH_AL);
            if (lmode == LM_LOW_FT || lmode == LM_HIGH_FT) begin
               s_d.fault = 1'b1;
               fset      = 1'b1;
            end
         end else begin
            s_d.loss_cnt = s_q.loss_cnt + 32'h0000_0001;
         end

         if ((cmpv < $signed({16'h0000, s_q.cfg[R_SLVL][15:0]})) != s_q.sleeping) begin
            if (s_q.sleep_cnt >= s_q.cfg[R_STIM]) begin
               s_d.sleeping  = !s_q.sleeping;
               s_d.sleep_cnt = 32'h0000_0000;
            end else begin
               s_d.sleep_cnt = s_q.sleep_cnt + 32'h0000_0001;
            end
         end else begin
            s_d.sleep_cnt = 32'h0000_0000;
         end
      end

      if (access && pwrite && !s_q.err) begin
         if (idx < R_STAT) begin
            s_d.cfg[idx] = pwdata;
         end else if (idx == R_STAT && pwdata[1] && !fset) begin
            // A fault raised in the same cycle wins over the clear
            s_d.fault = 1'b0;
         end
      end

      // Output stops at once on fault or sleep, not at the next tick
      if (s_d.fault || s_d.sleeping) begin
         s_d.fout = 16'sh0000;
      end
      s_d.run = !s_d.fault && !s_d.sleeping;
      s_d.evt = s_d.alarm || s_d.fault;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q              <= '0;
         s_q.cfg[R_CTRL]  <= CTRL_RST;
         s_q.cfg[R_DIN]   <= DIN_RST;
         s_q.cfg[R_KP]    <= {16'h0000, UNITY_GAIN};
         s_q.cfg[R_KI]    <= {16'h0000, UNITY_GAIN};
         s_q.cfg[R_ILIM]  <= {16'h0000, FULL_SCALE};
         s_q.cfg[R_OLIM]  <= {16'h0000, FULL_SCALE};
         s_q.cfg[R_GAIN]  <= {16'h0000, UNITY_GAIN};
         s_q.cfg[R_RAMP]  <= RAMP_RST;
         s_q.cfg[R_LTIM]  <= ONE_RST;
         s_q.cfg[R_STIM]  <= ONE_RST;
         s_q.cfg[R_SQG]   <= {16'h0000, UNITY_GAIN};
         s_q.run          <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata              = s_q.rdata;
   assign pready              = s_q.ready;
   assign pslverr             = s_q.err;
   assign freq_out            = s_q.fout;
   assign run_enable          = s_q.run;
   assign feedback_loss_event = s_q.evt;
   assign fault_out           = s_q.fault;
endmodule : pidc_top

/* File: pkg/pidc_pkg.sv */
package pidc_pkg;
   localparam int          DW          = 16;
   localparam int          NCFG        = 15;
   // Register word indices; byte address is index times four
   localparam logic [4:0]  R_CTRL      = 5'h00;
   localparam logic [4:0]  R_DIN       = 5'h01;
   localparam logic [4:0]  R_KP        = 5'h02;
   localparam logic [4:0]  R_KI        = 5'h03;
   localparam logic [4:0]  R_ILIM      = 5'h04;
   localparam logic [4:0]  R_OLIM      = 5'h05;
   localparam logic [4:0]  R_OFS       = 5'h06;
   localparam logic [4:0]  R_FILT      = 5'h07;
   localparam logic [4:0]  R_GAIN      = 5'h08;
   localparam logic [4:0]  R_RAMP      = 5'h09;
   localparam logic [4:0]  R_LLVL      = 5'h0a;
   localparam logic [4:0]  R_LTIM      = 5'h0b;
   localparam logic [4:0]  R_SLVL      = 5'h0c;
   localparam logic [4:0]  R_STIM      = 5'h0d;
   localparam logic [4:0]  R_SQG       = 5'h0e;
   localparam logic [4:0]  R_STAT      = 5'h0f;
   localparam logic [4:0]  R_OUT       = 5'h10;
   // Control word fields
   localparam int          C_EN        = 0;
   localparam int          C_METH      = 1;
   localparam int          C_POL       = 4;
   localparam int          C_NEG       = 5;
   localparam int          C_REVP      = 6;
   localparam int          C_SQRT      = 7;
   localparam int          C_LMODE     = 8;
   localparam int          C_MSEL      = 11;
   // Digital input function codes
   localparam logic [5:0]  F_DISABLE   = 6'h13;
   localparam logic [5:0]  F_IRESET    = 6'h1e;
   localparam logic [5:0]  F_IHOLD     = 6'h1f;
   localparam logic [5:0]  F_SOFTBYP   = 6'h22;
   localparam logic [5:0]  F_INVERT    = 6'h23;
   localparam int          NDIN        = 5;
   localparam int          FW          = 6;
   // Monitor select codes
   localparam logic [4:0]  M_CURR      = 5'h03;
   localparam logic [4:0]  M_SPEED     = 5'h05;
   localparam logic [4:0]  M_VOLT      = 5'h06;
   localparam logic [4:0]  M_BUS       = 5'h07;
   localparam logic [4:0]  M_POWER     = 5'h08;
   localparam logic [4:0]  M_TORQ      = 5'h09;
   localparam logic [4:0]  M_A1        = 5'h0f;
   localparam logic [4:0]  M_A2        = 5'h10;
   localparam logic [4:0]  M_SEC       = 5'h12;
   // Operating methods and loss modes
   localparam logic [2:0]  METH_ADD3   = 3'h3;
   localparam logic [2:0]  METH_ADD4   = 3'h4;
   localparam logic [2:0]  LM_LOW_AL   = 3'h1;
   localparam logic [2:0]  LM_LOW_FT   = 3'h2;
   localparam logic [2:0]  LM_HIGH_AL  = 3'h3;
   localparam logic [2:0]  LM_HIGH_FT  = 3'h4;
   // Scaling: 1000 counts = 100.0 % of maximum output frequency
   localparam logic [15:0] FULL_SCALE  = 16'h03e8;
   localparam logic [15:0] UNITY_GAIN  = 16'h0100;
   localparam int          GAIN_SHIFT  = 8;
   localparam int          SQRT_SHIFT  = 10;
   // Control tick: 1 ms at 200 MHz
   localparam int          CLK_MHZ     = 200;
   localparam int          TICK_US     = 1000;
   localparam int          TICK_CYC    = TICK_US * CLK_MHZ;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0002;
   localparam logic [31:0] DIN_RST     = 32'h0000_0000;
   localparam logic [31:0] ONE_RST     = 32'h0000_0001;
   localparam logic [31:0] RAMP_RST    = 32'h0000_03e8;
endpackage : pidc_pkg

/* File: tb/pidc_plant.sv */
`timescale 1ns/10ps
module pidc_plant (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic signed [pidc_pkg::DW-1:0] fb_set,
   input  wire logic signed [pidc_pkg::DW-1:0] fref_set,
   output logic signed [pidc_pkg::DW-1:0]      freq_ref,
   output logic signed [pidc_pkg::DW-1:0]      feedback_in,
   output logic signed [pidc_pkg::DW-1:0]      mon [9]
);
   import pidc_pkg::*;
   // Sensor and reference path lag the bench by one clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         feedback_in <= '0;
         freq_ref    <= '0;
      end else begin
         feedback_in <= fb_set;
         freq_ref    <= fref_set;
      end
   end
   // Each monitor carries its own distinct level
   always_comb begin
      for (int i = 0; i < 9; i++) begin
         mon[i] = 16'(40 * (i + 1));
      end
   end
endmodule : pidc_plant

/* File: tb/pidc_props.sv */
`timescale 1ns/10ps
module pidc_props #(
   parameter int TICK_CYCLES = pidc_pkg::TICK_CYC
) (
   input wire logic                           pclk,
   input wire logic                           presetn,
   input wire logic                           psel,
   input wire logic                           penable,
   input wire logic                           pwrite,
   input wire logic [11:0]                    paddr,
   input wire logic [31:0]                    pwdata,
   input wire logic [31:0]                    prdata,
   input wire logic                           pready,
   input wire logic                           pslverr,
   input wire logic signed [pidc_pkg::DW-1:0] freq_out,
   input wire logic                           run_enable,
   input wire logic                           feedback_loss_event,
   input wire logic                           fault_out
);
   import pidc_pkg::*;
   logic [31:0] hold_q;
   // Cycles since freq_out last moved
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= 32'(TICK_CYCLES);
      end else if ($changed(freq_out)) begin
         hold_q <= 32'h0;
      end else if (hold_q != 32'hffff_ffff) begin
         hold_q <= hold_q + 32'h1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_apb_wait; (psel && !penable) |=> !pready ##1 pready; endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("pready not after one wait");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   property p_ready_req; pready |-> $past(psel) && $past(penable); endproperty
   a_ready_req: assert property (p_ready_req) else $error("pready without access phase");
   property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("bad error response");
   property p_fault_stop; fault_out |-> feedback_loss_event && !run_enable; endproperty
   a_fault_stop: assert property (p_fault_stop) else $error("fault did not stop drive");
   property p_fault_hold;
      $fell(fault_out) |-> $past(pready) && $past(pwrite) && $past(pwdata[1])
         && $past(paddr) == 12'h03c;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault cleared without write");
   property p_sleep_zero; !run_enable [*2] |-> freq_out == '0; endproperty
   a_sleep_zero: assert property (p_sleep_zero) else $error("output while stopped");
   property p_out_hold; $changed(freq_out) |-> hold_q >= 32'(TICK_CYCLES - 1); endproperty
   a_out_hold: assert property (p_out_hold) else $error("output moved between ticks");
endmodule : pidc_props

bind pidc_top pidc_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .freq_out, .run_enable,
   .feedback_loss_event, .fault_out);

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   import pidc_pkg::*;
   localparam int TK = 8;
   localparam logic [4:0] MCODE [9] = '{M_CURR, M_SPEED, M_VOLT, M_BUS, M_POWER, M_TORQ,
      M_A1, M_A2, M_SEC};
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic run_enable, feedback_loss_event, fault_out;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic signed [DW-1:0] target = '0, fb = '0, fref = '0, freq_ref, feedback_in, freq_out;
   logic signed [DW-1:0] mon [9];
   logic [NDIN-1:0] din = '0;
   int n_mismatch = 0, n_checks = 0, cyc = 0, seed = 32'hb61f, t, f, o;
   always #2.5 pclk = ~pclk;
   pidc_plant plant_u (.pclk, .presetn, .fb_set(fb), .fref_set(fref), .freq_ref,
      .feedback_in, .mon);
   pidc_top #(.TICK_CYCLES(TK)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .target, .freq_ref, .feedback_in,
      .mon_current(mon[0]), .mon_speed(mon[1]), .mon_voltage(mon[2]), .mon_bus(mon[3]),
      .mon_power(mon[4]), .mon_torque(mon[5]), .mon_a1(mon[6]), .mon_a2(mon[7]),
      .mon_secondary(mon[8]), .din, .freq_out, .run_enable, .feedback_loss_event, .fault_out);
   task automatic final_report;
      if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {5'h0, a, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [4:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc
   task automatic tk(input int n);
      repeat (n * TK) @(posedge pclk);
   endtask : tk
   // Apply set point and feedback, let the loop settle, compare output
   task automatic pc(input int tv, input int fv, input int e);
      target <= 16'(tv);
      fb <= 16'(fv);
      tk(6);
      chk(32'(freq_out), 32'(e));
   endtask : pc
   // Proportional result with unity gain, clipped to limit and to zero
   function automatic int pexp(input int e, input int lim);
      return (e > lim) ? lim : ((e < 0) ? 0 : e);
   endfunction : pexp
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(R_CTRL, CTRL_RST);
      rdc(R_OLIM, 32'(FULL_SCALE));
      rdc(R_RAMP, RAMP_RST);
      rdc(R_STIM, ONE_RST);
      apb(1'b0, 5'h11, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      t = $random(seed) & 16'h7fff;
      wr(R_KP, 32'(t));
      rdc(R_KP, 32'(t));
      t = $random(seed) & 511;
      pc(t, 0, t);
      wr(R_KP, 32'h100);
      wr(R_GAIN, 32'h100);
      wr(R_KI, 32'h0);
      wr(R_DIN, 32'({F_INVERT, F_SOFTBYP, F_IHOLD, F_IRESET, F_DISABLE}));
      wr(R_CTRL, 32'h23);
      for (int i = 0; i < 6; i++) begin
         t = 300 + ($random(seed) & 255);
         f = $random(seed) & 127;
         o = $random(seed) & 63;
         wr(R_OFS, 32'(o));
         pc(t, f, pexp(t - f + o, 1000));
      end
      wr(R_OFS, 32'h0);
      wr(R_CTRL, 32'h33);
      pc(200, 500, 300);
      wr(R_CTRL, 32'h23);
      din <= 5'h10;
      pc(200, 500, 300);
      din <= 5'h0;
      wr(R_CTRL, 32'h63);
      pc(200, 500, 0);
      wr(R_CTRL, 32'h03);
      pc(200, 500, 0);
      wr(R_CTRL, 32'h23);
      wr(R_OLIM, 32'd100);
      pc(600, 100, pexp(500, 100));
      rdc(R_OUT, 32'd100);
      wr(R_OLIM, 32'd1000);
      wr(R_GAIN, 32'h200);
      pc(300, 100, 400);
      wr(R_GAIN, 32'h100);
      fref <= 16'd250;
      for (int m = 3; m < 5; m++) begin
         wr(R_CTRL, 32'h21 | 32'(m << 1));
         pc(400, 100, 550);
      end
      wr(R_CTRL, 32'ha3);
      wr(R_SQG, 32'h100);
      pc(500, 100, 180);
      wr(R_SQG, 32'h200);
      pc(800, 100, 160);
      for (int i = 0; i < 9; i++) begin
         wr(R_CTRL, 32'h23 | (32'(MCODE[i]) << 11));
         pc(500, 0, 500 - 40 * (i + 1));
      end
      wr(R_CTRL, 32'h23);
      pc(500, 100, 400);
      din <= 5'h1;
      pc(123, 0, 123);
      din <= 5'h0;
      wr(R_KP, 32'h0);
      wr(R_KI, 32'h100);
      wr(R_ILIM, 32'd50);
      pc(300, 200, 50);
      din <= 5'h4;
      pc(100, 300, 50);
      din <= 5'h2;
      pc(300, 300, 0);
      din <= 5'h0;
      wr(R_KI, 32'h0);
      wr(R_KP, 32'h100);
      pc(0, 0, 0);
      wr(R_RAMP, 32'd10);
      target <= 16'd500;
      tk(3);
      chk({31'h0, freq_out < 16'sd100}, 32'h1);
      din <= 5'h8;
      pc(500, 0, 500);
      din <= 5'h0;
      wr(R_RAMP, 32'd1000);
      wr(R_LLVL, 32'd100);
      wr(R_LTIM, 32'd2);
      for (int m = 1; m < 5; m++) begin
         f = (m < 3) ? 50 : 900;
         wr(R_CTRL, 32'h23 | 32'(m << 8));
         fb <= 16'(f);
         target <= 16'(f);
         tk(6);
         chk({31'h0, feedback_loss_event}, 32'h1);
         chk({30'h0, fault_out, run_enable}, (m % 2 == 0) ? 32'h2 : 32'h1);
         rdc(R_STAT, (m % 2 == 0) ? 32'h6 : 32'h5);
         fb <= 16'd100;
         target <= 16'd100;
         tk(4);
         wr(R_STAT, 32'h2);
         chk({30'h0, fault_out, feedback_loss_event}, 32'h0);
      end
      wr(R_LTIM, 32'd3);
      wr(R_CTRL, 32'h123);
      for (int i = 0; i < 3; i++) begin
         fb <= (i == 1) ? 16'd100 : 16'd50;
         tk(2);
      end
      chk({31'h0, feedback_loss_event}, 32'h0);
      tk(4);
      chk({31'h0, feedback_loss_event}, 32'h1);
      wr(R_CTRL, 32'h23);
      wr(R_SLVL, 32'd300);
      wr(R_STIM, 32'd2);
      pc(300, 200, 0);
      chk({31'h0, run_enable}, 32'h0);
      pc(800, 200, 600);
      chk({31'h0, run_enable}, 32'h1);
      wr(R_CTRL, 32'h22);
      fref <= 16'd100;
      pc(100, 0, 0);
      fref <= 16'd500;
      pc(500, 0, 500);
      final_report();
   end
endmodule : tb_top
